// ### rtl/fes_pkg.sv
// constants, register map and array operation codes of the erase / program-once sequencer
package fes_pkg;
    localparam logic [7:0] FES_ADDR_STATUS = 8'h00;
    localparam logic [7:0] FES_ADDR_INDEX = 8'h04;
    localparam logic [7:0] FES_ADDR_PARAM = 8'h08;
    localparam logic [7:0] FES_ADDR_PROT = 8'h0c;
    localparam logic [7:0] FES_ADDR_MODE = 8'h10;
    localparam logic [7:0] FES_ADDR_SEC = 8'h14;
    // status bit positions
    localparam int FES_ST_DONE = 7;
    localparam int FES_ST_ACC = 5;
    localparam int FES_ST_PROT = 4;
    localparam int FES_ST_VERR = 1;
    localparam int FES_ST_VUNC = 0;
    // command codes
    localparam logic [7:0] FES_CMD_PROG_ONCE = 8'h07;
    localparam logic [7:0] FES_CMD_ERASE_ALL = 8'h08;
    localparam logic [7:0] FES_CMD_ERASE_BLK = 8'h09;
    localparam logic [7:0] FES_CMD_ERASE_SECT = 8'h0a;
    localparam logic [7:0] FES_CMD_UNSECURE = 8'h0b;
    // index the parameter pointer must hold at launch
    localparam logic [2:0] FES_IDX_NONE = 3'h0;
    localparam logic [2:0] FES_IDX_ADDR = 3'h1;
    localparam logic [2:0] FES_IDX_DATA = 3'h5;
    localparam int FES_PARAM_SLOTS = 6;
    localparam logic [15:0] FES_PHRASE_MAX = 16'h0007;
    localparam logic [2:0] FES_ALIGN_PHRASE = 3'h0;
    localparam logic [63:0] FES_ERASED = 64'hffff_ffff_ffff_ffff;
    // commands allowed outside special mode, one bit per command code
    localparam logic [15:0] FES_NORMAL_PERMIT = 16'h0780;
    // sector number sits in the top three address bits, from this bit up
    localparam int FES_SECT_LSB = 13;
    // reset values
    localparam logic [7:0] FES_STATUS_RST = 8'h80;
    localparam logic [8:0] FES_PROT_RST = 9'h000;
    localparam logic FES_SEC_RST = 1'b1;
    localparam logic [2:0] FES_INDEX_RST = 3'h0;

    typedef enum logic [2:0] {
        FOP_READ_ONCE,
        FOP_PROG_ONCE,
        FOP_ERASE_ALL,
        FOP_ERASE_BLK,
        FOP_ERASE_SECT,
        FOP_VFY_ALL,
        FOP_VFY_BLK,
        FOP_VFY_SECT
    } fes_op_e;
endpackage

// ### rtl/fes_sequencer.sv
// erase / program-once command sequencer with its register port and array handshake
//
// Implementation choices: the plain strobed port and the register addresses.
module fes_sequencer
    import fes_pkg::*;
#(
    parameter logic [6:0] PF_BLOCK = 7'h00,
    parameter logic [6:0] DF_BLOCK = 7'h10
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [15:0] rdata,
    output logic fl_start,
    output fes_pkg::fes_op_e fl_op,
    output logic [6:0] fl_block,
    output logic [15:0] fl_addr,
    output logic [63:0] fl_wdata,
    input wire logic fl_done,
    input wire logic [63:0] fl_rdata,
    input wire logic fl_err,
    input wire logic fl_uncorr,
    output logic pf0_read_invalid,
    output logic secured
);
    import fes_pkg::*;

    typedef enum logic {ST_IDLE, ST_RUN} fes_state_e;

    fes_state_e state_reg;
    fes_op_e op_reg;
    logic start_reg;
    logic vfy_reg;
    logic [7:0] status_reg;
    logic [2:0] index_reg;
    logic [15:0] param_mem [FES_PARAM_SLOTS];
    logic [8:0] prot_reg;
    logic special_reg;
    logic secured_reg;
    logic [15:0] rdata_reg;
    logic [6:0] block_reg;
    logic [15:0] faddr_reg;

    logic [7:0] cmd;
    logic [6:0] blk;
    logic [15:0] lo;
    logic wr_status;
    logic launch;
    logic acc_next;
    logic prot_next;
    logic permitted;
    logic [2:0] sect;
    fes_op_e first_op;
    logic [63:0] phrase_data;
    logic run_done;
    logic vfy_fail;

    function automatic logic is_verify(input fes_op_e op, input logic vfy);
        is_verify = (op == FOP_VFY_ALL) || (op == FOP_VFY_BLK) || (op == FOP_VFY_SECT) ||
                    ((op == FOP_READ_ONCE) && vfy);
    endfunction

    assign cmd = param_mem[0][15:8];
    assign blk = param_mem[0][6:0];
    assign lo = param_mem[1];
    assign sect = lo[FES_SECT_LSB +: 3];
    assign phrase_data = {param_mem[5], param_mem[4], param_mem[3], param_mem[2]};
    assign permitted = special_reg | FES_NORMAL_PERMIT[cmd[3:0]];
    assign wr_status = wr_en && (addr == FES_ADDR_STATUS);
    assign launch = wr_status && wdata[FES_ST_DONE] && status_reg[FES_ST_DONE];

    // launch-time parameter and protection checks
    always_comb begin
        acc_next = 1'b0;
        prot_next = 1'b0;
        first_op = FOP_READ_ONCE;
        if (!permitted || cmd[7:4] != 4'h0) begin
            acc_next = 1'b1;
        end
        case (cmd)
            FES_CMD_PROG_ONCE: begin
                first_op = FOP_READ_ONCE;
                if (index_reg != FES_IDX_DATA) begin
                    acc_next = 1'b1;
                end
                if (lo > FES_PHRASE_MAX) begin
                    acc_next = 1'b1;
                end
            end
            FES_CMD_ERASE_ALL, FES_CMD_UNSECURE: begin
                first_op = FOP_ERASE_ALL;
                if (index_reg != FES_IDX_NONE) begin
                    acc_next = 1'b1;
                end
                if (prot_reg != FES_PROT_RST) begin
                    prot_next = 1'b1;
                end
            end
            FES_CMD_ERASE_BLK: begin
                first_op = FOP_ERASE_BLK;
                if (index_reg != FES_IDX_ADDR) begin
                    acc_next = 1'b1;
                end
                if (blk == PF_BLOCK) begin
                    if (lo[2:0] != FES_ALIGN_PHRASE) begin
                        acc_next = 1'b1;
                    end
                    if (prot_reg[7:0] != 8'h00) begin
                        prot_next = 1'b1;
                    end
                end else if (blk == DF_BLOCK) begin
                    if (lo[0]) begin
                        acc_next = 1'b1;
                    end
                    if (prot_reg[8]) begin
                        prot_next = 1'b1;
                    end
                end else begin
                    acc_next = 1'b1;
                end
            end
            FES_CMD_ERASE_SECT: begin
                first_op = FOP_ERASE_SECT;
                if (index_reg != FES_IDX_ADDR || blk != PF_BLOCK) begin
                    acc_next = 1'b1;
                end
                if (lo[2:0] != FES_ALIGN_PHRASE) begin
                    acc_next = 1'b1;
                end
                if (prot_reg[sect]) begin
                    prot_next = 1'b1;
                end
            end
            default: begin
                acc_next = 1'b1;
            end
        endcase
    end

    assign run_done = (state_reg == ST_RUN) && fl_done && !start_reg;
    assign vfy_fail = fl_err || (op_reg == FOP_READ_ONCE && fl_rdata != phrase_data);

    // command sequencing
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            op_reg <= FOP_READ_ONCE;
            start_reg <= 1'b0;
            vfy_reg <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (launch && !acc_next && !prot_next) begin
                        state_reg <= ST_RUN;
                        op_reg <= first_op;
                        start_reg <= 1'b1;
                        vfy_reg <= 1'b0;
                    end
                end
                ST_RUN: begin
                    if (run_done) begin
                        case (op_reg)
                            FOP_READ_ONCE: begin
                                if (!vfy_reg && fl_rdata == FES_ERASED) begin
                                    op_reg <= FOP_PROG_ONCE;
                                    start_reg <= 1'b1;
                                end else begin
                                    state_reg <= ST_IDLE;
                                end
                            end
                            FOP_PROG_ONCE: begin
                                op_reg <= FOP_READ_ONCE;
                                vfy_reg <= 1'b1;
                                start_reg <= 1'b1;
                            end
                            FOP_ERASE_ALL: begin
                                op_reg <= FOP_VFY_ALL;
                                start_reg <= 1'b1;
                            end
                            FOP_ERASE_BLK: begin
                                op_reg <= FOP_VFY_BLK;
                                start_reg <= 1'b1;
                            end
                            FOP_ERASE_SECT: begin
                                op_reg <= FOP_VFY_SECT;
                                start_reg <= 1'b1;
                            end
                            default: begin
                                state_reg <= ST_IDLE;
                            end
                        endcase
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // array block and address latched at launch; write data comes straight from the parameter slots
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            block_reg <= 7'h00;
            faddr_reg <= 16'h0000;
        end else if (launch && state_reg == ST_IDLE) begin
            block_reg <= blk;
            faddr_reg <= lo;
        end
    end

    // status flags: hardware set wins over software clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status_reg <= FES_STATUS_RST;
        end else begin
            if (wr_status && state_reg == ST_IDLE) begin
                status_reg[FES_ST_ACC] <= status_reg[FES_ST_ACC] & ~wdata[FES_ST_ACC];
                status_reg[FES_ST_PROT] <= status_reg[FES_ST_PROT] & ~wdata[FES_ST_PROT];
            end
            if (launch && state_reg == ST_IDLE) begin
                status_reg[FES_ST_VERR] <= 1'b0;
                status_reg[FES_ST_VUNC] <= 1'b0;
                if (acc_next) begin
                    status_reg[FES_ST_ACC] <= 1'b1;
                end
                if (prot_next) begin
                    status_reg[FES_ST_PROT] <= 1'b1;
                end
                // done clear only while work runs
                if (!acc_next && !prot_next) begin
                    status_reg[FES_ST_DONE] <= 1'b0;
                end
            end
            if (run_done) begin
                if (op_reg == FOP_READ_ONCE && !vfy_reg && fl_rdata != FES_ERASED) begin
                    status_reg[FES_ST_ACC] <= 1'b1;
                end
                if (is_verify(op_reg, vfy_reg)) begin
                    if (vfy_fail) begin
                        status_reg[FES_ST_VERR] <= 1'b1;
                    end
                    if (fl_uncorr) begin
                        status_reg[FES_ST_VUNC] <= 1'b1;
                    end
                end
                // done flag after last step; a clean erased check goes on to program
                if (is_verify(op_reg, vfy_reg) ||
                    (op_reg == FOP_READ_ONCE && fl_rdata != FES_ERASED)) begin
                    status_reg[FES_ST_DONE] <= 1'b1;
                end
            end
        end
    end

    // security state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            secured_reg <= FES_SEC_RST;
        end else if (run_done && op_reg == FOP_VFY_ALL && !fl_err && !fl_uncorr) begin
            secured_reg <= 1'b0;
        end
    end

    // software-written registers; busy writes are dropped
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            index_reg <= FES_INDEX_RST;
            prot_reg <= FES_PROT_RST;
            special_reg <= 1'b0;
            for (int i = 0; i < FES_PARAM_SLOTS; i++) begin
                param_mem[i] <= 16'h0000;
            end
        end else if (wr_en && state_reg == ST_IDLE) begin
            if (addr == FES_ADDR_INDEX) begin
                index_reg <= wdata[2:0];
            end else if (addr == FES_ADDR_PARAM) begin
                // words land in the indexed slot
                if (index_reg < 3'(FES_PARAM_SLOTS)) begin
                    param_mem[index_reg] <= wdata;
                end
            end else if (addr == FES_ADDR_PROT) begin
                prot_reg <= wdata[8:0];
            end else if (addr == FES_ADDR_MODE) begin
                special_reg <= wdata[0];
            end
        end
    end

    // read port, data one cycle after strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= 16'h0000;
        end else if (rd_en) begin
            if (addr == FES_ADDR_STATUS) begin
                rdata_reg <= {8'h00, status_reg};
            end else if (addr == FES_ADDR_INDEX) begin
                rdata_reg <= {13'h0000, index_reg};
            end else if (addr == FES_ADDR_PARAM && index_reg < 3'(FES_PARAM_SLOTS)) begin
                rdata_reg <= param_mem[index_reg];
            end else if (addr == FES_ADDR_PROT) begin
                rdata_reg <= {7'h00, prot_reg};
            end else if (addr == FES_ADDR_MODE) begin
                rdata_reg <= {15'h0000, special_reg};
            end else if (addr == FES_ADDR_SEC) begin
                rdata_reg <= {15'h0000, secured_reg};
            end else begin
                rdata_reg <= 16'h0000;
            end
        end
    end

    assign rdata = rdata_reg;
    assign fl_start = start_reg;
    assign fl_op = op_reg;
    assign fl_block = block_reg;
    assign fl_addr = faddr_reg;
    assign fl_wdata = phrase_data;
    assign secured = secured_reg;
    // block 0 read data invalid during program-once
    assign pf0_read_invalid = (state_reg == ST_RUN) &&
                              (op_reg == FOP_READ_ONCE || op_reg == FOP_PROG_ONCE);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_check_clean;
        run_done && op_reg == FOP_READ_ONCE && !vfy_reg && fl_rdata == FES_ERASED;
    endsequence
    sequence s_check_dirty;
        run_done && op_reg == FOP_READ_ONCE && !vfy_reg && fl_rdata != FES_ERASED;
    endsequence

    chk_launch_busy: assert property (launch && !acc_next && !prot_next |=>
        !status_reg[FES_ST_DONE] && fl_start) else $error("accepted launch did not start");
    chk_reject_done: assert property (launch && (acc_next || prot_next) |=>
        status_reg[FES_ST_DONE] && state_reg == ST_IDLE) else $error("rejected launch ran");
    chk_index_once: assert property (launch && cmd == FES_CMD_PROG_ONCE &&
        index_reg != FES_IDX_DATA |=> status_reg[FES_ST_ACC]) else $error("index not caught");
    chk_phrase_range: assert property (launch && cmd == FES_CMD_PROG_ONCE &&
        lo > FES_PHRASE_MAX |=> status_reg[FES_ST_ACC] && !fl_start)
        else $error("bad phrase index accepted");
    chk_once_program: assert property (s_check_clean |=>
        fl_start && op_reg == FOP_PROG_ONCE && !status_reg[FES_ST_DONE])
        else $error("erased phrase not programmed");
    chk_once_refuse: assert property (s_check_dirty |=>
        status_reg[FES_ST_ACC] && status_reg[FES_ST_DONE] && state_reg == ST_IDLE)
        else $error("programmed phrase not refused");
    chk_blk0_invalid: assert property (launch && cmd == FES_CMD_PROG_ONCE && !acc_next &&
        !prot_next |=> pf0_read_invalid && fl_op == FOP_READ_ONCE)
        else $error("block 0 reads not marked invalid");
    chk_sect_align: assert property (launch && cmd == FES_CMD_ERASE_SECT &&
        lo[2:0] != FES_ALIGN_PHRASE |=> status_reg[FES_ST_ACC])
        else $error("misaligned sector address accepted");
    chk_prot_all: assert property (launch && (cmd == FES_CMD_ERASE_ALL ||
        cmd == FES_CMD_UNSECURE) && prot_reg != FES_PROT_RST |=> status_reg[FES_ST_PROT])
        else $error("protection not flagged on full erase");
    chk_vfy_err: assert property (run_done && is_verify(op_reg, vfy_reg) && fl_err |=>
        status_reg[FES_ST_VERR] && status_reg[FES_ST_DONE]) else $error("verify error lost");
    chk_sec_hold: assert property (run_done && op_reg == FOP_VFY_ALL && fl_err |=>
        $stable(secured_reg)) else $error("security changed on failed verify");
endmodule

// ### testbench/fes_flash_model.sv
// behavioural array responder holding only the program-once field, seen across the array link
module fes_flash_model
    import fes_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic fl_start,
    input wire fes_pkg::fes_op_e fl_op,
    input wire logic [15:0] fl_addr,
    input wire logic [63:0] fl_wdata,
    input wire logic [3:0] lat,
    input wire logic err_inj,
    input wire logic unc_inj,
    output logic fl_done,
    output logic [63:0] fl_rdata,
    output logic fl_err,
    output logic fl_uncorr
);
    timeunit 1ns;
    timeprecision 100ps;
    // nonvolatile, so the once field survives reset
    logic [63:0] once_mem [8] = '{default: FES_ERASED};
    logic [3:0] cnt;
    logic busy;
    logic [63:0] last = '0;
    // phrase keeps what it was programmed with
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy <= 1'b0;
            fl_done <= 1'b0;
        end else begin
            fl_done <= 1'b0;
            if (fl_start) begin
                busy <= 1'b1;
                cnt <= lat;
            end else if (busy && cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else if (busy) begin
                busy <= 1'b0;
                fl_done <= 1'b1;
                if (fl_op == FOP_PROG_ONCE) once_mem[fl_addr[2:0]] <= fl_wdata;
                last <= once_mem[fl_addr[2:0]];
            end
        end
    end
    // faults only on verify steps, only when injected
    assign fl_err = fl_done & err_inj & (fl_op >= FOP_VFY_ALL);
    assign fl_uncorr = fl_done & unc_inj & (fl_op >= FOP_VFY_ALL);
    // read data is not held once the answer is gone
    assign fl_rdata = fl_done ? last : ~last;
endmodule

// ### testbench/testbench.sv
// self-checking bench for the erase / program-once sequencer
module testbench
    import fes_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic [3:0] lat = 4'h2;
    logic err_inj = 1'b0;
    logic unc_inj = 1'b0;
    int inv_cycles = 0;
    logic [15:0] rdata, rv;
    logic [15:0] pw [6];
    logic fl_start, fl_done, fl_err, fl_uncorr, pf0_read_invalid, secured;
    fes_op_e fl_op;
    logic [6:0] fl_block;
    logic [15:0] fl_addr;
    logic [63:0] fl_wdata, fl_rdata;
    int err_count = 0;
    int n_compared = 0;

    always #2.5 clk = ~clk;
    always @(posedge clk) if (pf0_read_invalid === 1'b1) inv_cycles <= inv_cycles + 1;

    fes_sequencer u_fes_sequencer (.clk, .rst_b, .addr, .wdata, .wr_en, .rd_en, .rdata,
        .fl_start, .fl_op, .fl_block, .fl_addr, .fl_wdata, .fl_done, .fl_rdata, .fl_err,
        .fl_uncorr, .pf0_read_invalid, .secured);
    fes_flash_model u_fes_flash_model (.clk, .rst_b, .fl_start, .fl_op, .fl_addr,
        .fl_wdata, .lat, .err_inj, .unc_inj, .fl_done, .fl_rdata, .fl_err, .fl_uncorr);

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    function automatic logic [15:0] s0(input logic [7:0] c, input logic [6:0] b);
        return {c, 1'b0, b};
    endfunction
    // load slots, set index, launch, poll done and judge the status
    task automatic run(input int n, input logic [2:0] ix, input logic [15:0] exp);
        int k;
        for (k = 0; k < n; k++) begin
            wr(FES_ADDR_INDEX, 16'(k));
            wr(FES_ADDR_PARAM, pw[k]);
        end
        wr(FES_ADDR_INDEX, {13'h0, ix});
        wr(FES_ADDR_STATUS, 16'h0080);
        rd(FES_ADDR_STATUS, rv);
        // exp[15]: refusal found by the array check, so done drops first
        chk({15'h0, rv[FES_ST_DONE]}, {15'h0, (exp[5] | exp[4]) & ~exp[15]});
        // only reads while the command runs
        for (k = 0; k < 100 && rv[FES_ST_DONE] !== 1'b1; k++) rd(FES_ADDR_STATUS, rv);
        if (rv[FES_ST_DONE] !== 1'b1) begin
            err_count++;
            end_of_test();
        end
        chk(rv, {8'h00, exp[7:0]});
        wr(FES_ADDR_STATUS, 16'h0030);
    endtask
    task automatic t_block();
        pw[0] = s0(FES_CMD_ERASE_BLK, 7'h10);
        pw[1] = 16'h0000;
        run(2, FES_IDX_ADDR, 16'h0080);
        chk({9'h000, fl_block}, 16'h0010);
        run(2, 3'h2, 16'h00a0);
        pw[1] = 16'h0001;
        run(2, FES_IDX_ADDR, 16'h00a0);
        pw[0] = s0(FES_CMD_ERASE_BLK, 7'h33);
        run(2, FES_IDX_ADDR, 16'h00a0);
        pw[0] = s0(FES_CMD_ERASE_BLK, 7'h00);
        pw[1] = 16'h0004;
        run(2, FES_IDX_ADDR, 16'h00a0);
        pw[1] = 16'h0000;
        wr(FES_ADDR_PROT, 16'h0001);
        run(2, FES_IDX_ADDR, 16'h0090);
        wr(FES_ADDR_PROT, 16'h0000);
        err_inj <= 1'b1;
        unc_inj <= 1'b1;
        run(2, FES_IDX_ADDR, 16'h0083);
        err_inj <= 1'b0;
        unc_inj <= 1'b0;
        pw[0] = s0(FES_CMD_ERASE_SECT, 7'h00);
        pw[1] = 16'h2008;
        run(2, FES_IDX_ADDR, 16'h0080);
        chk(fl_addr, 16'h2008);
        pw[1] = 16'h2003;
        run(2, FES_IDX_ADDR, 16'h00a0);
        pw[1] = 16'h3ff8;
        wr(FES_ADDR_PROT, 16'h0002);
        run(2, FES_IDX_ADDR, 16'h0090);
        wr(FES_ADDR_PROT, 16'h0000);
        $display("block and sector erase test done");
    endtask
    task automatic t_once();
        int inv0;
        lat <= 4'h9;
        inv0 = inv_cycles;
        chk(16'(inv0), 16'h0000);
        pw[0] = s0(FES_CMD_PROG_ONCE, 7'h00);
        pw[1] = 16'h0008;
        for (int k = 2; k < 6; k++) pw[k] = 16'(16'h1111 * (k - 1));
        run(6, FES_IDX_DATA, 16'h00a0);
        pw[1] = 16'h0002;
        run(6, 3'h4, 16'h00a0);
        run(6, FES_IDX_DATA, 16'h0080);
        chk({15'h0, inv_cycles > inv0}, 16'h0001);
        chk(u_fes_flash_model.once_mem[2][63:48], 16'h4444);
        run(6, FES_IDX_DATA, 16'h80a0);
        pw[1] = 16'h0003;
        for (int k = 2; k < 6; k++) pw[k] = 16'hffff;
        run(6, FES_IDX_DATA, 16'h0080);
        run(6, FES_IDX_DATA, 16'h0080);
        $display("program once test done");
    endtask
    task automatic t_all();
        lat <= 4'h3;
        pw[0] = s0(FES_CMD_ERASE_ALL, 7'h00);
        run(1, FES_IDX_ADDR, 16'h00a0);
        wr(FES_ADDR_PROT, 16'h0100);
        run(1, FES_IDX_NONE, 16'h0090);
        wr(FES_ADDR_PROT, 16'h0000);
        run(1, FES_IDX_NONE, 16'h0080);
        chk({15'h0, secured}, 16'h0000);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        chk({15'h0, secured}, 16'h0001);
        pw[0] = s0(FES_CMD_UNSECURE, 7'h00);
        run(1, FES_IDX_NONE, 16'h00a0);
        wr(FES_ADDR_MODE, 16'h0001);
        err_inj <= 1'b1;
        run(1, FES_IDX_NONE, 16'h0082);
        chk({15'h0, secured}, 16'h0001);
        err_inj <= 1'b0;
        run(1, FES_IDX_NONE, 16'h0080);
        chk({15'h0, secured}, 16'h0000);
        $display("erase all and unsecure test done");
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd(FES_ADDR_STATUS, rv);
        chk(rv, FES_STATUS_RST);
        t_block();
        t_once();
        t_all();
        end_of_test();
    end
endmodule
